// ---- hw/dcache_line_ctrl.sv ----
`timescale 1ns/1ps
module dcache_line_ctrl
   import dcache_pkg::*;
#(
   parameter logic [7:0] RAND_SEED = LFSR_SEED
) (
   input  wire logic        clock,       // 125 MHz clock
   input  wire logic        srst,        // synchronous reset, high
   input  wire cpu_req_s    cpu_req,     // cpu operand request
   output      logic        cpu_ready,   // cpu request can be taken this cycle
   input  wire snoop_req_s  snoop_req,   // snooped bus access
   output      action_s     act,         // registered action, one cycle
   input  wire logic        hsel,        // ahb slave select
   input  wire logic [31:0] haddr,       // ahb address
   input  wire logic [1:0]  htrans,      // ahb transfer type
   input  wire logic        hwrite,      // ahb write
   input  wire logic [2:0]  hsize,       // ahb size
   input  wire logic [31:0] hwdata,      // ahb write data
   input  wire logic        hready,      // ahb bus ready
   output      logic [31:0] hrdata,      // ahb read data
   output      logic        hreadyout,   // ahb slave ready
   output      logic        hresp        // ahb response
);

   // line state storage
   line_state_e      state_ff [NUM_SETS][WAYS];
   logic [LW_N-1:0]  dirty_ff [NUM_SETS][WAYS];
   logic [7:0]       lfsr_ff;
   logic [1:0]       ctrl_ff;
   logic [SET_W-1:0] q_set_ff;
   logic [WAY_W-1:0] q_way_ff;
   logic             wr_pend_ff;
   logic [7:0]       wr_addr_ff;
   logic [31:0]      hrdata_ff;
   action_s          act_ff;

   // first invalid way, else the random way
   function automatic logic [WAY_W-1:0] pick_way(
      input line_state_e      st [WAYS],
      input logic [WAY_W-1:0] rnd);
      logic [WAY_W-1:0] w;
      logic             found;
      w     = rnd;
      found = 1'b0;
      for (int i = 0; i < WAYS; i++) begin
         if (!found && st[i] == LINE_INVALID) begin
            w     = WAY_W'(i);
            found = 1'b1;
         end
      end
      return w;
   endfunction

   // arbitration: snoops win over cpu requests
   wire logic snoop_take = snoop_req.valid & ctrl_ff[CTRL_SNOOP_EN];
   wire logic cpu_take   = cpu_req.valid & cpu_ready;
   assign cpu_ready = ctrl_ff[CTRL_CPU_EN] & ~snoop_take;

   // line state views
   line_state_e set_st [WAYS];
   always_comb begin
      for (int i = 0; i < WAYS; i++) begin
         set_st[i] = state_ff[cpu_req.set][i];
      end
   end
   wire logic [WAY_W-1:0] victim   = pick_way(set_st, lfsr_ff[1:0]);
   wire logic             cpu_miss = ~cpu_req.hit &
                                     (cpu_req.op == OP_READ ||
                                      cpu_req.op == OP_WRITE);
   wire logic [WAY_W-1:0] cpu_way  = cpu_miss ? victim : cpu_req.way;
   wire line_state_e      cpu_st   = state_ff[cpu_req.set][cpu_way];
   wire logic [LW_N-1:0]  cpu_dty  = dirty_ff[cpu_req.set][cpu_way];
   wire line_state_e      snp_st   = state_ff[snoop_req.set][snoop_req.way];
   wire logic [LW_N-1:0]  snp_dty  = dirty_ff[snoop_req.set][snoop_req.way];
   wire logic             copyback =
      cpu_req.page_cache_mode_field == CM_COPYBACK;
   wire logic             cpu_vdty = cpu_st == LINE_DIRTY;
   wire logic             snp_vdty = snp_st == LINE_DIRTY;
   wire logic             snp_hit  = snoop_req.hit &
                                     snp_st != LINE_INVALID;

   // next action and line update
   action_s nxt_act;
   logic    upd_en;
   always_comb begin
      nxt_act = '0;
      nxt_act.new_state = LINE_INVALID;
      upd_en = 1'b0;
      if (snoop_take) begin
         nxt_act.set  = snoop_req.set;
         nxt_act.way  = snoop_req.way;
         nxt_act.new_state = snp_st;
         nxt_act.long_word_dirty_bits = snp_dty;
         if (snp_hit) begin
            case (snoop_req.snoop_ctrl)
               SNOOP_LEAVE_DIRTY: begin
                  if (!snoop_req.write) begin
                     // leave-dirty read: dirty line sources data
                     nxt_act.valid          = snp_vdty;
                     nxt_act.inhibit_memory = snp_vdty;
                     nxt_act.source_data    = snp_vdty;
                  end else if (!snoop_req.size_is_line &&
                               snp_vdty) begin
                     // partial write absorbed by dirty line
                     nxt_act.valid          = 1'b1;
                     nxt_act.inhibit_memory = 1'b1;
                     nxt_act.sink_data      = 1'b1;
                     nxt_act.long_word_dirty_bits =
                        snp_dty | snoop_req.lw_mask;
                     upd_en = 1'b1;
                  end else begin
                     // valid line, or full-line write: drop copy
                     nxt_act.valid     = 1'b1;
                     nxt_act.new_state = LINE_INVALID;
                     nxt_act.long_word_dirty_bits = '0;
                     upd_en = 1'b1;
                  end
               end
               SNOOP_INVALIDATE: begin
                  // any hit invalidates; dirty read sources first
                  nxt_act.valid = 1'b1;
                  nxt_act.inhibit_memory = snp_vdty & ~snoop_req.write;
                  nxt_act.source_data    = snp_vdty & ~snoop_req.write;
                  nxt_act.new_state = LINE_INVALID;
                  nxt_act.long_word_dirty_bits = '0;
                  upd_en = 1'b1;
               end
               default: begin
                  nxt_act.valid = 1'b0;                       // not snooped
               end
            endcase
         end
      end else if (cpu_take) begin
         nxt_act.valid = 1'b1;
         nxt_act.set   = cpu_req.set;
         nxt_act.way   = cpu_way;
         nxt_act.new_state = cpu_st;
         nxt_act.long_word_dirty_bits = cpu_dty;
         case (cpu_req.op)
            OP_READ: begin
               nxt_act.supply_cpu = 1'b1;
               if (!cpu_req.hit) begin
                  // fill the victim, copy back a dirty one
                  nxt_act.fetch_line    = 1'b1;
                  nxt_act.buffer_victim = cpu_vdty;
                  nxt_act.copy_back     = cpu_vdty;
                  nxt_act.new_state     = LINE_VALID;
                  nxt_act.long_word_dirty_bits = '0;
                  upd_en = 1'b1;
               end
            end
            OP_WRITE: begin
               if (!copyback) begin
                  // write-through: memory always, cache on hit
                  nxt_act.write_memory = 1'b1;
                  nxt_act.merge_write  = cpu_req.hit;
                  nxt_act.way          = cpu_req.way;
                  nxt_act.new_state    = state_ff[cpu_req.set][cpu_req.way];
                  nxt_act.long_word_dirty_bits =
                     dirty_ff[cpu_req.set][cpu_req.way];
               end else begin
                  // copyback: allocate on miss, merge, mark dirty
                  nxt_act.fetch_line    = ~cpu_req.hit;
                  nxt_act.buffer_victim = ~cpu_req.hit & cpu_vdty;
                  nxt_act.copy_back     = ~cpu_req.hit & cpu_vdty;
                  nxt_act.merge_write   = 1'b1;
                  nxt_act.new_state     = LINE_DIRTY;
                  nxt_act.long_word_dirty_bits = cpu_req.hit ?
                     (cpu_dty | cpu_req.lw_mask) : cpu_req.lw_mask;
                  upd_en = 1'b1;
               end
            end
            OP_INVALIDATE: begin
               // discard contents, no memory traffic
               nxt_act.new_state = LINE_INVALID;
               nxt_act.long_word_dirty_bits = '0;
               upd_en = 1'b1;
            end
            OP_PUSH: begin
               // copy back dirty data, then invalidate
               nxt_act.copy_back = cpu_vdty;
               nxt_act.new_state = LINE_INVALID;
               nxt_act.long_word_dirty_bits = '0;
               upd_en = 1'b1;
            end
            default: begin
               nxt_act.valid = 1'b0;
            end
         endcase
      end
   end

   // line state array update
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int s = 0; s < NUM_SETS; s++) begin
            for (int w = 0; w < WAYS; w++) begin
               state_ff[s][w] <= LINE_INVALID;
               dirty_ff[s][w] <= '0;
            end
         end
      end else if (upd_en) begin
         state_ff[nxt_act.set][nxt_act.way] <= nxt_act.new_state;
         dirty_ff[nxt_act.set][nxt_act.way] <=
            nxt_act.long_word_dirty_bits;
      end
   end

   // action register and replacement lfsr
   wire logic [7:0] nxt_lfsr = lfsr_ff[0] ?
                               ((lfsr_ff >> 1) ^ LFSR_TAPS) :
                               (lfsr_ff >> 1);
   always_ff @(posedge clock) begin
      if (srst) begin
         act_ff  <= '0;
         lfsr_ff <= RAND_SEED;
      end else begin
         act_ff  <= nxt_act;
         lfsr_ff <= nxt_lfsr;
      end
   end
   assign act = act_ff;

   // ahb-lite slave: address phase decode
   wire logic       ahb_acc = hsel & htrans[1] & hready;
   wire logic [7:0] ahb_adr = haddr[ADDR_W-1:0];
   wire logic [31:0] line_word = {
      {(32 - LINE_DIRTY_LSB - LW_N){1'b0}},
      dirty_ff[q_set_ff][q_way_ff],
      1'b0,
      state_ff[q_set_ff][q_way_ff]};
   wire logic [31:0] rd_value =
      (ahb_adr == REG_CTRL)  ? {30'h0, ctrl_ff} :
      (ahb_adr == REG_QUERY) ? {22'h0, q_way_ff, 2'h0, q_set_ff} :
      (ahb_adr == REG_LINE)  ? line_word : 32'h0;

   // ahb-lite slave: write data phase and read data capture
   wire logic wr_ctrl  = wr_pend_ff & (wr_addr_ff == REG_CTRL);
   wire logic wr_query = wr_pend_ff & (wr_addr_ff == REG_QUERY);
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata_ff  <= 32'h0;
         ctrl_ff    <= CTRL_RESET;
         q_set_ff   <= '0;
         q_way_ff   <= '0;
      end else begin
         wr_pend_ff <= ahb_acc & hwrite;
         wr_addr_ff <= ahb_adr;
         if (ahb_acc && !hwrite) begin
            hrdata_ff <= rd_value;
         end
         if (wr_ctrl) begin
            ctrl_ff <= hwdata[1:0];
         end
         if (wr_query) begin
            q_set_ff <= hwdata[SET_W-1:0];
            q_way_ff <= hwdata[QUERY_WAY_LSB +: WAY_W];
         end
      end
   end
   assign hrdata    = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

endmodule

// ---- hw/dcache_pkg.sv ----
// Function
// - read miss on valid/invalid line: fill, supply cpu, go valid
// - read miss on dirty victim: buffer, fill, supply, copy back; valid
// - read hit: supply cached data, no memory access, state unchanged
// - copyback write miss on invalid/valid: fill, merge, mark dirty
// - copyback write miss on dirty victim: buffer, fill, merge, copy back
// - write-through write miss: write memory only, no allocation, no change
// - copyback write hit on valid: update cache, set dirty bits, go dirty
// - copyback write hit on dirty: update cache, add dirty bits, stay dirty
// - write-through write hit on valid: update cache and memory, stay valid
// - write-through write hit on dirty: cache and memory, bits untouched
// - invalidate instruction: line goes invalid, dirty data discarded
// - push: dirty line copied back then invalid; valid invalidated
// - snoop read, leave-dirty, valid line: no action, stays valid
// - snoop read, leave-dirty, dirty line: inhibit memory, source data
// - snoop read, invalidate: valid invalidated; dirty sourced then invalid
// - snoop write, invalidate encoding: valid or dirty line goes invalid
// - snoop write sink, partial: dirty line absorbs data; valid invalid
// - snoop write sink, full line: line invalidated, memory not inhibited
// - fill picks an invalid way first, else pseudo-random victim of four
// - copyback or write-through policy comes from the page cache mode field
package dcache_pkg;

   // cache geometry
   localparam int SET_W     = 6;
   localparam int NUM_SETS  = 64;
   localparam int WAYS      = 4;
   localparam int WAY_W     = 2;
   localparam int LW_N      = 4;

   // line states, one-hot
   typedef enum logic [2:0] {
      LINE_INVALID = 3'h1,
      LINE_VALID   = 3'h2,
      LINE_DIRTY   = 3'h4
   } line_state_e;

   // cpu operations
   typedef enum logic [1:0] {
      OP_READ       = 2'h0,
      OP_WRITE      = 2'h1,
      OP_INVALIDATE = 2'h2,
      OP_PUSH       = 2'h3
   } cpu_op_e;

   // snoop control and page mode encodings
   localparam logic [1:0] SNOOP_LEAVE_DIRTY = 2'h1;
   localparam logic [1:0] SNOOP_INVALIDATE  = 2'h2;
   localparam logic       CM_COPYBACK       = 1'h0;
   localparam logic       CM_WRITETHROUGH   = 1'h1;

   // cpu operand request
   typedef struct packed {
      logic             valid;
      cpu_op_e          op;
      logic             page_cache_mode_field;
      logic             hit;
      logic [WAY_W-1:0] way;
      logic [SET_W-1:0] set;
      logic [LW_N-1:0]  lw_mask;
   } cpu_req_s;

   // snooped alternate-master access
   typedef struct packed {
      logic             valid;
      logic             write;
      logic [1:0]       snoop_ctrl;
      logic             size_is_line;
      logic             hit;
      logic [WAY_W-1:0] way;
      logic [SET_W-1:0] set;
      logic [LW_N-1:0]  lw_mask;
   } snoop_req_s;

   // action issued toward bus controller and data array
   typedef struct packed {
      logic             valid;
      logic             fetch_line;
      logic             buffer_victim;
      logic             copy_back;
      logic             write_memory;
      logic             supply_cpu;
      logic             merge_write;
      logic             inhibit_memory;
      logic             source_data;
      logic             sink_data;
      logic [WAY_W-1:0] way;
      logic [SET_W-1:0] set;
      line_state_e      new_state;
      logic [LW_N-1:0]  long_word_dirty_bits;
   } action_s;

   // register map
   localparam int          ADDR_W    = 8;
   localparam logic [7:0]  REG_CTRL  = 8'h00;
   localparam logic [7:0]  REG_QUERY = 8'h04;
   localparam logic [7:0]  REG_LINE  = 8'h08;
   localparam int          CTRL_CPU_EN   = 0;
   localparam int          CTRL_SNOOP_EN = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h3;
   localparam int          QUERY_WAY_LSB = 8;
   localparam int          LINE_DIRTY_LSB = 4;
   localparam logic [7:0]  LFSR_SEED = 8'hA5;
   localparam logic [7:0]  LFSR_TAPS = 8'hB8;

endpackage

// ---- verification/dcache_line_ctrl_chk.sv ----
`timescale 1ns/1ps
module dcache_line_ctrl_chk
   import dcache_pkg::*;
(
   input wire logic       clock,      // clock
   input wire logic       srst,       // sync reset
   input wire cpu_req_s   cpu_req,    // cpu request
   input wire logic       cpu_ready,  // cpu ready
   input wire snoop_req_s snoop_req,  // snoop request
   input wire action_s    act         // action out
);
   default clocking dck @(posedge clock);
   endclocking
   default disable iff (srst);
   // a request is taken; snoop is only seen with cpu held off
   wire logic cpu_tk = cpu_req.valid && cpu_ready;
   wire logic snp_tk = snoop_req.valid && snoop_req.hit && !cpu_ready;
   sequence s_cpu(o, m, h);
      cpu_tk && cpu_req.op == o && cpu_req.page_cache_mode_field == m
         && cpu_req.hit == h;
   endsequence
   sequence s_snp(w, c, l);
      snp_tk && snoop_req.write == w && snoop_req.snoop_ctrl == c
         && snoop_req.size_is_line == l;
   endsequence
   // cpu side
   a_read_fill: assert property (s_cpu(OP_READ, CM_COPYBACK, 1'h0) |=>
      act.valid && act.fetch_line && act.supply_cpu
      && act.new_state == LINE_VALID) else $error("read miss action");
   a_read_hit: assert property (s_cpu(OP_READ, CM_COPYBACK, 1'h1) |=>
      act.supply_cpu && !act.fetch_line && !act.write_memory
      && !act.copy_back) else $error("read hit action");
   a_cb_wmiss: assert property (s_cpu(OP_WRITE, CM_COPYBACK, 1'h0) |=>
      act.fetch_line && act.merge_write && act.new_state == LINE_DIRTY
      && act.long_word_dirty_bits == $past(cpu_req.lw_mask))
      else $error("copyback write miss action");
   a_wt_wmiss: assert property (
      s_cpu(OP_WRITE, CM_WRITETHROUGH, 1'h0) |=>
      act.valid && act.write_memory && !act.fetch_line && !act.merge_write)
      else $error("write-through miss action");
   a_cb_whit: assert property (
      s_cpu(OP_WRITE, CM_COPYBACK, 1'h1) |=>
      act.merge_write && !act.write_memory && act.new_state == LINE_DIRTY
      && (act.long_word_dirty_bits & $past(cpu_req.lw_mask))
      == $past(cpu_req.lw_mask)) else $error("copyback write hit action");
   a_wt_whit: assert property (
      s_cpu(OP_WRITE, CM_WRITETHROUGH, 1'h1) |=>
      act.merge_write && act.write_memory && act.new_state != LINE_INVALID)
      else $error("write-through hit action");
   a_inval_quiet: assert property (
      cpu_tk && cpu_req.op == OP_INVALIDATE
      |=> !act.copy_back && !act.write_memory
      && (!act.valid || act.new_state == LINE_INVALID))
      else $error("invalidate action");
   a_push_inval: assert property (cpu_tk && cpu_req.op == OP_PUSH |=>
      !act.fetch_line && (!act.valid || act.new_state == LINE_INVALID))
      else $error("push action");
   // snoop side
   a_snoop_miss: assert property (snoop_req.valid && !snoop_req.hit
      && !cpu_ready |=> !act.valid) else $error("snoop miss acted");
   a_snoop_rinv: assert property (
      s_snp(1'h0, SNOOP_INVALIDATE, 1'h0) |=>
      !act.valid || act.new_state == LINE_INVALID)
      else $error("snoop read invalidate");
   a_snoop_winv: assert property (
      s_snp(1'h1, SNOOP_INVALIDATE, 1'h0) |=>
      !act.inhibit_memory && !act.sink_data
      && (!act.valid || act.new_state == LINE_INVALID))
      else $error("snoop write invalidate");
   a_sink_full: assert property (
      s_snp(1'h1, SNOOP_LEAVE_DIRTY, 1'h1) |=>
      !act.inhibit_memory && (!act.valid || act.new_state == LINE_INVALID))
      else $error("full line snoop write");
endmodule

bind dcache_line_ctrl dcache_line_ctrl_chk chk_u (
   .clock(clock), .srst(srst), .cpu_req(cpu_req), .cpu_ready(cpu_ready),
   .snoop_req(snoop_req), .act(act));

// ---- verification/dcache_mem_model.sv ----
`timescale 1ns/1ps
module dcache_mem_model
   import dcache_pkg::*;
(
   input  wire logic    clock,    // clock
   input  wire logic    srst,     // sync reset
   input  wire action_s act,      // device action
   output      int      n_fetch,  // line fills served
   output      int      n_store   // memory writes taken
);
   // memory serves every fill and takes every copy-back or store
   always_ff @(posedge clock) begin
      if (srst) begin
         n_fetch <= 0;
         n_store <= 0;
      end else if (act.valid) begin
         n_fetch <= n_fetch + int'(act.fetch_line);
         n_store <= n_store
                    + int'(act.copy_back | act.write_memory);
      end
   end
endmodule

// ---- verification/dcache_line_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module dcache_line_ctrl_tb_top
   import dcache_pkg::*;
   ;
   localparam logic       CB = CM_COPYBACK;
   localparam logic       WT = CM_WRITETHROUGH;
   localparam logic [1:0] LD = SNOOP_LEAVE_DIRTY;
   localparam logic [1:0] IV = SNOOP_INVALIDATE;
   // bench signals
   logic        clock, srst, cpu_ready, hsel, hwrite, hreadyout, hresp;
   cpu_req_s    cpu_req;
   snoop_req_s  snoop_req;
   action_s     act, last;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [5:0]  cur_set;
   int          n_fetch, n_store, failures, n_compared;
   dcache_line_ctrl dut_u (
      .clock(clock), .srst(srst), .cpu_req(cpu_req), .cpu_ready(cpu_ready),
      .snoop_req(snoop_req), .act(act), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp));
   dcache_mem_model mem_u (
      .clock(clock), .srst(srst), .act(act), .n_fetch(n_fetch),
      .n_store(n_store));
   // clock toggles every half period of 4 ns
   always #4 clock = ~clock;
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", what, e, g);
      end
   endtask
   // waits for an edge with hready high, bounded
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge clock);
      while (hreadyout !== 1'h1) begin
         n++;
         if (n > 50) begin
            failures++;
            wrap_up();
         end
         @(posedge clock);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      r = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask
   task automatic line_chk(input logic [1:0] w, input logic [31:0] e);
      ahb(1'h1, REG_QUERY, {22'h0, w, 2'h0, cur_set}, rd);
      ahb(1'h0, REG_LINE, 32'h0, rd);
      chk("line state", e, rd);
   endtask
   // one request, then the action one cycle after it is taken
   task automatic go(input cpu_req_s c, input snoop_req_s s,
                     input logic [9:0] ef, input line_state_e es,
                     input logic [3:0] ed);
      @(posedge clock);
      cpu_req <= c;
      snoop_req <= s;
      @(posedge clock);
      cpu_req <= '0;
      snoop_req <= '0;
      @(posedge clock);
      last = act;
      chk("act flags", 32'(ef), 32'(last[24:15]));
      if (ef[9]) begin
         chk("new state", 32'(es), 32'(last.new_state));
      end
      if (ef[9] && es != LINE_INVALID) begin
         chk("dirty bits", 32'(ed), 32'(last.long_word_dirty_bits));
      end
   endtask
   task automatic cpu_go(input cpu_op_e o, input logic m, input logic h,
                         input logic [3:0] k, input logic [9:0] ef,
                         input line_state_e es, input logic [3:0] ed);
      go('{1'h1, o, m, h, 2'h0, cur_set, k}, '0, ef, es, ed);
   endtask
   task automatic snp_go(input logic w, input logic [1:0] c, input logic l,
                         input logic h, input logic [3:0] k,
                         input logic [9:0] ef, input line_state_e es,
                         input logic [3:0] ed);
      go('0, '{1'h1, w, c, l, h, 2'h0, cur_set, k}, ef, es, ed);
   endtask
   task automatic t_regs;
      ahb(1'h0, REG_CTRL, 32'h0, rd);
      chk("ctrl reset", {30'h0, CTRL_RESET}, rd);
      ahb(1'h1, 8'h0C, 32'hFFFFFFFF, rd);
      ahb(1'h0, 8'h0C, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      ahb(1'h1, REG_CTRL, 32'h2, rd);
      @(posedge clock);
      chk("cpu ready off", 32'h0, 32'(cpu_ready));
      ahb(1'h1, REG_CTRL, 32'h3, rd);
      cur_set = 6'h00;
      line_chk(2'h0, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_cpu;
      cur_set = 6'h01;
      cpu_go(OP_READ,CB,1'h0,4'h0,10'h310,LINE_VALID,4'h0);
      cpu_go(OP_READ,CB,1'h1,4'h0,10'h210,LINE_VALID,4'h0);
      cpu_go(OP_WRITE,CB,1'h1,4'h3,10'h208,LINE_DIRTY,4'h3);
      cpu_go(OP_WRITE,CB,1'h1,4'h4,10'h208,LINE_DIRTY,4'h7);
      line_chk(2'h0, 32'h74);
      cpu_go(OP_WRITE,WT,1'h1,4'h8,10'h228,LINE_DIRTY,4'h7);
      cpu_go(OP_WRITE,WT,1'h0,4'h1,10'h220,LINE_DIRTY,4'h7);
      cpu_go(OP_PUSH,CB,1'h1,4'h0,10'h240,LINE_INVALID,4'h0);
      cpu_go(OP_WRITE,CB,1'h0,4'h1,10'h308,LINE_DIRTY,4'h1);
      cpu_go(OP_INVALIDATE,CB,1'h1,4'h0,10'h200,LINE_INVALID,4'h0);
      line_chk(2'h0, 32'h1);
      $display("test cpu done");
   endtask
   task automatic t_snoop;
      cur_set = 6'h02;
      cpu_go(OP_READ,CB,1'h0,4'h0,10'h310,LINE_VALID,4'h0);
      snp_go(1'h0,LD,1'h0,1'h1,4'h0,10'h000,LINE_VALID,4'h0);
      cpu_go(OP_WRITE,WT,1'h1,4'h1,10'h228,LINE_VALID,4'h0);
      cpu_go(OP_WRITE,CB,1'h1,4'h1,10'h208,LINE_DIRTY,4'h1);
      snp_go(1'h0,LD,1'h0,1'h1,4'h0,10'h206,LINE_DIRTY,4'h1);
      snp_go(1'h1,LD,1'h0,1'h1,4'h2,10'h205,LINE_DIRTY,4'h3);
      line_chk(2'h0, 32'h34);
      snp_go(1'h0,IV,1'h0,1'h1,4'h0,10'h206,LINE_INVALID,4'h0);
      cpu_go(OP_READ,CB,1'h0,4'h0,10'h310,LINE_VALID,4'h0);
      snp_go(1'h1,IV,1'h0,1'h0,4'h0,10'h000,LINE_INVALID,4'h0);
      snp_go(1'h1,LD,1'h1,1'h1,4'hF,10'h200,LINE_INVALID,4'h0);
      cpu_go(OP_READ,CB,1'h0,4'h0,10'h310,LINE_VALID,4'h0);
      snp_go(1'h1,IV,1'h0,1'h1,4'h0,10'h200,LINE_INVALID,4'h0);
      $display("test snoop done");
   endtask
   task automatic t_victim;
      cur_set = 6'h03;
      for (int w = 0; w < WAYS; w++) begin
         cpu_go(OP_WRITE,CB,1'h0,4'hF,10'h308,LINE_DIRTY,4'hF);
         chk("fill way", 32'(w), 32'(last.way));
      end
      cpu_go(OP_READ,CB,1'h0,4'h0,10'h3D0,LINE_VALID,4'h0);
      repeat (2) @(posedge clock);
      chk("fills", 32'hA, 32'(n_fetch));
      chk("stores", 32'h5, 32'(n_store));
      $display("test victim done");
   endtask
   // reset, then the scenarios in turn
   initial begin
      clock = 1'h0;
      srst = 1'h1;
      cpu_req = '0;
      snoop_req = '0;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      failures = 0;
      n_compared = 0;
      repeat (6) @(posedge clock);
      srst <= 1'h0;
      t_regs();
      t_cpu();
      t_snoop();
      t_victim();
      wrap_up();
   end
endmodule
